// ### rtl/power_seq_pkg.sv
// Shared constants for the module power on/off sequencing link
// Contract
// RQ1: Host holds power key low 2 s
// RQ2: Key low beyond 70 ms starts power-on
// RQ3: Operational no earlier than 20 s
// RQ4: Host sends no command before ready
// RQ5: Software-ready high only when commands accepted
// RQ6: Power-monitor high once pads configured
// RQ7: Host drives power key open-drain only
// RQ8: Key tied low powers on at supply
// RQ9: Host keeps lines low while module off
// RQ10: Host allows 2-6 s command answer wait
// RQ11: Shutdown sends network detach request first
// RQ12: Both monitor lines low means off
// RQ13: Shutdown command enters finalization, then lines drop
// RQ14: Software-off completion judged by monitor line
// RQ15: Host holds key low 2.5 s for off
// RQ16: Key low beyond 2.5 s while on: finalize
// RQ17: Hardware-off completion judged by monitor line
// RQ18: Host holds emergency line low 200 ms
// RQ19: Host drives emergency line open-drain only
// RQ20: Emergency path only as last exit
// RQ21: Supply off only after confirmed shutdown
// RQ22: Enabled fast-off falling edge: off within 30 ms
// RQ23: Host synchronises monitor inputs in two stages
// RQ24: Host rejects requests mid-sequence, flags timeouts
package power_seq_pkg;

  // ==========================================================
  // Timebase
  localparam int CNT_W = 40;
  localparam longint unsigned CLK_HZ = 64'h000000000BEBC200;
  localparam longint unsigned CYC_PER_MS = CLK_HZ / 64'h00000000000003E8;

  // ==========================================================
  // Times in milliseconds
  localparam longint unsigned KEY_ON_MS = 64'h00000000000007D0;
  localparam longint unsigned KEY_OFF_MS = 64'h00000000000009C4;
  localparam longint unsigned GLITCH_MS = 64'h0000000000000046;
  localparam longint unsigned BOOT_MS = 64'h0000000000004E20;
  localparam longint unsigned PADS_MS = 64'h0000000000002710;
  localparam longint unsigned EMERG_MS = 64'h00000000000000C8;
  localparam longint unsigned FAST_OFF_MS = 64'h000000000000001E;
  localparam longint unsigned RESP_MIN_MS = 64'h00000000000007D0;
  localparam longint unsigned RESP_MAX_MS = 64'h0000000000001770;
  localparam longint unsigned SW_OFF_TYP_MS = 64'h0000000000002710;
  localparam longint unsigned HW_OFF_TYP_MS = 64'h0000000000003A98;
  localparam longint unsigned TIMEOUT_MS = 64'h000000000000EA60;

  // ==========================================================
  // Times in clock cycles
  localparam logic [CNT_W-1:0] KEY_ON_CYC = CNT_W'(KEY_ON_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] KEY_OFF_CYC = CNT_W'(KEY_OFF_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] GLITCH_CYC = CNT_W'(GLITCH_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] BOOT_CYC = CNT_W'(BOOT_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] PADS_CYC = CNT_W'(PADS_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] EMERG_CYC = CNT_W'(EMERG_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] FAST_OFF_CYC = CNT_W'(FAST_OFF_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] RESP_MAX_CYC = CNT_W'(RESP_MAX_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] TIMEOUT_CYC = CNT_W'(TIMEOUT_MS * CYC_PER_MS);
  // Margin past the device's strict "longer than" compare
  localparam logic [CNT_W-1:0] HOLD_MARGIN_CYC = CNT_W'(64'h0000000000000004);

  typedef enum logic [2:0] {
    DEV_OFF,
    DEV_BOOT,
    DEV_ACTIVE,
    DEV_FINAL
  } dev_state_t;

  typedef enum logic [2:0] {
    HST_IDLE,
    HST_PRESS_ON,
    HST_WAIT_UP,
    HST_READY,
    HST_PRESS_OFF,
    HST_WAIT_DOWN,
    HST_EMERG
  } host_state_t;

endpackage : power_seq_pkg

// ### rtl/power_link_if.sv
// Link between host controller and module power control lines
`timescale 1ns/1ps
`default_nettype none
interface power_link_if;
  logic keyOut;
  logic keyOe;
  logic emergencyOut;
  logic emergencyOe;
  logic shutdownCommand;
  logic powerMonitor;
  logic softwareReady;
  logic powerKeyN;
  logic emergencyOffN;

  // ==========================================================
  // Open-drain lines with the module's internal pull-up
  assign powerKeyN = keyOe ? keyOut : 1'b1;
  assign emergencyOffN = emergencyOe ? emergencyOut : 1'b1;

  modport host (
    output keyOut,
    output keyOe,
    output emergencyOut,
    output emergencyOe,
    output shutdownCommand,
    input powerMonitor,
    input softwareReady,
    input powerKeyN,
    input emergencyOffN
  );

  modport device (
    input powerKeyN,
    input emergencyOffN,
    input shutdownCommand,
    output powerMonitor,
    output softwareReady
  );
endinterface : power_link_if
`default_nettype wire

// ### rtl/hold_counter.sv
// Saturating counter of consecutive cycles a level is held
`timescale 1ns/1ps
`default_nettype none
module hold_counter #(
  parameter int W = 40
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic level,
  output logic [W-1:0] count
);
  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;

  always_comb begin
    if (!level) begin
      nxt_count = '0;
    end else if (&count_ff) begin
      nxt_count = count_ff;
    end else begin
      nxt_count = W'(count_ff + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;
endmodule : hold_counter
`default_nettype wire

// ### rtl/power_seq_device.sv
// Module-side power sequencer: boot, finalization and forced off
`timescale 1ns/1ps
`default_nettype none
module power_seq_device
  import power_seq_pkg::*;
#(
  parameter logic [CNT_W-1:0] GLITCH_CYCLES = GLITCH_CYC,
  parameter logic [CNT_W-1:0] PADS_CYCLES = PADS_CYC,
  parameter logic [CNT_W-1:0] BOOT_CYCLES = BOOT_CYC,
  parameter logic [CNT_W-1:0] KEY_OFF_CYCLES = KEY_OFF_CYC,
  parameter logic [CNT_W-1:0] EMERG_CYCLES = EMERG_CYC
) (
  input wire logic clk,
  input wire logic srst,
  power_link_if.device link,
  input wire logic fastOffEnable,
  input wire logic fastOffPin,
  input wire logic finalizeDone,
  output logic detachReq,
  output logic finalizing
);
  dev_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] timer_ff, nxt_timer;
  logic armed_ff, nxt_armed;
  logic fastPrev_ff;
  logic monitor_ff, nxt_monitor;
  logic ready_ff, nxt_ready;
  logic detach_ff, nxt_detach;
  logic final_ff;
  logic [CNT_W-1:0] keyLowCnt;
  logic [CNT_W-1:0] emergLowCnt;
  logic fastFall;
  logic forceOff;

  hold_counter #(.W(CNT_W)) keyHold (
    .clk(clk),
    .srst(srst),
    .level(!link.powerKeyN),
    .count(keyLowCnt)
  );

  hold_counter #(.W(CNT_W)) emergHold (
    .clk(clk),
    .srst(srst),
    .level(!link.emergencyOffN),
    .count(emergLowCnt)
  );

  // ==========================================================
  // Sequencer
  assign fastFall = fastOffEnable && fastPrev_ff && !fastOffPin;
  // Forced exits skip detach and finalization
  assign forceOff = (emergLowCnt >= EMERG_CYCLES) || fastFall; // RQ22

  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    nxt_armed = armed_ff || link.powerKeyN;
    nxt_monitor = monitor_ff;
    nxt_ready = ready_ff;
    nxt_detach = 1'b0;
    unique case (state_ff)
      DEV_OFF: begin
        // Reset arms, so a grounded key powers on at supply-up
        if (armed_ff && keyLowCnt > GLITCH_CYCLES) begin // RQ2 RQ8
          nxt_state = DEV_BOOT;
          nxt_timer = CNT_W'(keyLowCnt + 1'b1); // RQ3
        end
      end
      DEV_BOOT: begin
        nxt_timer = CNT_W'(timer_ff + 1'b1);
        if (timer_ff >= PADS_CYCLES) begin
          nxt_monitor = 1'b1; // RQ6
        end
        if (timer_ff >= BOOT_CYCLES && timer_ff >= PADS_CYCLES) begin
          nxt_state = DEV_ACTIVE; // RQ3
          nxt_ready = 1'b1; // RQ5
        end
      end
      DEV_ACTIVE: begin
        if (link.shutdownCommand || keyLowCnt > KEY_OFF_CYCLES) begin // RQ13 RQ16
          nxt_state = DEV_FINAL;
          nxt_detach = 1'b1; // RQ11
          nxt_armed = 1'b0;
        end
      end
      DEV_FINAL: begin
        if (finalizeDone) begin
          nxt_state = DEV_OFF;
          nxt_monitor = 1'b0; // RQ12 RQ13
          nxt_ready = 1'b0;
        end
      end
      default: begin
        nxt_state = DEV_OFF;
      end
    endcase
    if (forceOff && state_ff != DEV_OFF) begin
      nxt_state = DEV_OFF;
      nxt_monitor = 1'b0; // RQ12
      nxt_ready = 1'b0;
      nxt_detach = 1'b0;
      nxt_armed = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= DEV_OFF;
      timer_ff <= '0;
      armed_ff <= 1'b1;
      fastPrev_ff <= 1'b0;
      monitor_ff <= 1'b0;
      ready_ff <= 1'b0;
      detach_ff <= 1'b0;
      final_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      armed_ff <= nxt_armed;
      fastPrev_ff <= fastOffPin;
      monitor_ff <= nxt_monitor;
      ready_ff <= nxt_ready;
      detach_ff <= nxt_detach;
      final_ff <= (nxt_state == DEV_FINAL);
    end
  end

  assign link.powerMonitor = monitor_ff;
  assign link.softwareReady = ready_ff;
  assign detachReq = detach_ff;
  assign finalizing = final_ff;
endmodule : power_seq_device
`default_nettype wire

// ### rtl/power_seq_host.sv
// Host-side controller driving module power key and emergency line
`timescale 1ns/1ps
`default_nettype none
module power_seq_host
  import power_seq_pkg::*;
#(
  parameter logic [CNT_W-1:0] ON_HOLD_CYCLES = KEY_ON_CYC,
  parameter logic [CNT_W-1:0] OFF_HOLD_CYCLES = CNT_W'(KEY_OFF_CYC + HOLD_MARGIN_CYC),
  parameter logic [CNT_W-1:0] EMERG_HOLD_CYCLES = CNT_W'(EMERG_CYC + HOLD_MARGIN_CYC),
  parameter logic [CNT_W-1:0] TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic srst,
  power_link_if.host link,
  input wire logic reqPowerOn,
  input wire logic reqHwOff,
  input wire logic reqSwOff,
  input wire logic reqEmergency,
  output logic busy,
  output logic moduleReady,
  output logic timeoutErr,
  output logic requestRejected,
  output logic supplyOffOk
);
  host_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] timer_ff, nxt_timer;
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic keyOe_ff, nxt_keyOe;
  logic emergOe_ff, nxt_emergOe;
  logic driveLow_ff;
  logic cmd_ff, nxt_cmd;
  logic busy_ff, nxt_busy;
  logic ready_ff, nxt_ready;
  logic err_ff, nxt_err;
  logic rej_ff, nxt_rej;
  logic supply_ff, nxt_supply;
  logic monitorUp;
  logic readyUp;
  logic anyReq;
  logic timerDone;

  // ==========================================================
  // Monitor line synchronisers
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
    end else begin
      sync1_ff <= {link.softwareReady, link.powerMonitor}; // RQ23
      sync2_ff <= sync1_ff; // RQ23
    end
  end

  assign monitorUp = sync2_ff[0];
  assign readyUp = sync2_ff[1];
  assign anyReq = reqPowerOn || reqHwOff || reqSwOff;
  assign timerDone = (timer_ff >= TIMEOUT_CYCLES);

  // ==========================================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_timer = CNT_W'(timer_ff + 1'b1);
    nxt_keyOe = 1'b0;
    nxt_emergOe = 1'b0;
    nxt_cmd = 1'b0;
    nxt_ready = 1'b0;
    nxt_err = err_ff;
    nxt_rej = 1'b0;
    nxt_supply = supply_ff;
    unique case (state_ff)
      HST_IDLE: begin
        nxt_timer = '0;
        if (reqPowerOn) begin
          nxt_state = HST_PRESS_ON;
          nxt_keyOe = 1'b1; // RQ1 RQ7
          nxt_err = 1'b0;
          nxt_supply = 1'b0;
        end else if (reqHwOff || reqSwOff) begin
          nxt_rej = 1'b1; // RQ24
        end
      end
      HST_PRESS_ON: begin
        nxt_keyOe = 1'b1; // RQ1
        nxt_rej = anyReq; // RQ24
        if (timer_ff >= CNT_W'(ON_HOLD_CYCLES - 1'b1)) begin
          nxt_state = HST_WAIT_UP;
          nxt_keyOe = 1'b0; // RQ1
          nxt_timer = '0;
        end
      end
      HST_WAIT_UP: begin
        nxt_rej = anyReq; // RQ4 RQ24
        if (readyUp && monitorUp) begin
          nxt_state = HST_READY;
          nxt_ready = 1'b1; // RQ4
        end else if (timerDone) begin
          nxt_state = HST_IDLE;
          nxt_err = 1'b1; // RQ24
        end
      end
      HST_READY: begin
        nxt_ready = 1'b1;
        nxt_timer = '0;
        if (!readyUp && !monitorUp) begin
          nxt_state = HST_IDLE;
          nxt_ready = 1'b0;
          nxt_supply = 1'b1; // RQ12
        end else if (reqHwOff) begin
          nxt_state = HST_PRESS_OFF;
          nxt_keyOe = 1'b1; // RQ15 RQ7
          nxt_ready = 1'b0;
        end else if (reqSwOff) begin
          // Command only while the module answers commands
          nxt_state = HST_WAIT_DOWN;
          nxt_cmd = 1'b1; // RQ4 RQ9
          nxt_ready = 1'b0;
        end else if (reqPowerOn) begin
          nxt_rej = 1'b1; // RQ24
        end
      end
      HST_PRESS_OFF: begin
        nxt_keyOe = 1'b1; // RQ15
        nxt_rej = anyReq; // RQ24
        if (timer_ff >= CNT_W'(OFF_HOLD_CYCLES - 1'b1)) begin
          nxt_state = HST_WAIT_DOWN;
          nxt_keyOe = 1'b0; // RQ15
          nxt_timer = '0;
        end
      end
      HST_WAIT_DOWN: begin
        // No fixed delay: the monitor lines decide, bounded by a timeout
        nxt_rej = anyReq; // RQ24
        if (!readyUp && !monitorUp) begin // RQ12 RQ14 RQ17
          nxt_state = HST_IDLE;
          nxt_supply = 1'b1; // RQ21
        end else if (timerDone) begin // RQ10 RQ14 RQ17
          nxt_state = HST_IDLE;
          nxt_err = 1'b1; // RQ24
        end
      end
      HST_EMERG: begin
        nxt_emergOe = 1'b1; // RQ18 RQ19
        nxt_rej = anyReq; // RQ24
        if (timer_ff >= CNT_W'(EMERG_HOLD_CYCLES - 1'b1)) begin
          nxt_state = HST_WAIT_DOWN;
          nxt_emergOe = 1'b0; // RQ18
          nxt_timer = '0;
        end
      end
      default: begin
        nxt_state = HST_IDLE;
      end
    endcase
    // Emergency exit overrides any sequence, only on explicit request
    if (reqEmergency && state_ff != HST_EMERG) begin // RQ20
      nxt_state = HST_EMERG;
      nxt_timer = '0;
      nxt_keyOe = 1'b0;
      nxt_emergOe = 1'b1; // RQ18 RQ19
      nxt_cmd = 1'b0;
      nxt_ready = 1'b0;
      nxt_rej = 1'b0;
      nxt_supply = 1'b0;
    end
    nxt_busy = (nxt_state != HST_IDLE) && (nxt_state != HST_READY);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= HST_IDLE;
      timer_ff <= '0;
      keyOe_ff <= 1'b0;
      emergOe_ff <= 1'b0;
      driveLow_ff <= 1'b0;
      cmd_ff <= 1'b0;
      busy_ff <= 1'b0;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      rej_ff <= 1'b0;
      supply_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      keyOe_ff <= nxt_keyOe;
      emergOe_ff <= nxt_emergOe;
      driveLow_ff <= 1'b0; // RQ7 RQ19
      cmd_ff <= nxt_cmd;
      busy_ff <= nxt_busy;
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
      rej_ff <= nxt_rej;
      supply_ff <= nxt_supply;
    end
  end

  // ==========================================================
  // Outputs
  assign link.keyOut = driveLow_ff;
  assign link.keyOe = keyOe_ff;
  assign link.emergencyOut = driveLow_ff;
  assign link.emergencyOe = emergOe_ff;
  assign link.shutdownCommand = cmd_ff;
  assign busy = busy_ff;
  assign moduleReady = ready_ff;
  assign timeoutErr = err_ff;
  assign requestRejected = rej_ff;
  assign supplyOffOk = supply_ff;
endmodule : power_seq_host
`default_nettype wire

// ### verification/power_seq_monitor.sv
// Concurrent checks on the power link between host and module sequencers
`timescale 1ns/1ps
`default_nettype none
module power_seq_monitor #(
  parameter int ON_HOLD = 20,
  parameter int OFF_HOLD = 34,
  parameter int EMERG_HOLD = 14,
  parameter int PADS = 40,
  parameter int BOOT = 60,
  parameter int KEY_OFF = 30
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic keyOut,
  input wire logic keyOe,
  input wire logic emergencyOut,
  input wire logic emergencyOe,
  input wire logic shutdownCommand,
  input wire logic powerMonitor,
  input wire logic softwareReady,
  input wire logic powerKeyN,
  input wire logic emergencyOffN
);
  logic [15:0] keyHold_ff;
  logic [15:0] emergHold_ff;
  logic [15:0] sinceKey_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // Helper counters
  // Time since key fell while off; saturates so long runs stay quiet
  always_ff @(posedge clk) begin
    if (srst) begin
      keyHold_ff <= 16'h0000;
      emergHold_ff <= 16'h0000;
      sinceKey_ff <= 16'hFFFF;
    end else begin
      keyHold_ff <= keyOe ? keyHold_ff + 16'h0001 : 16'h0000;
      emergHold_ff <= emergencyOe ? emergHold_ff + 16'h0001 : 16'h0000;
      if ($fell(powerKeyN) && !powerMonitor) begin
        sinceKey_ff <= 16'h0001;
      end else if (sinceKey_ff != 16'hFFFF) begin
        sinceKey_ff <= sinceKey_ff + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Assertions
  readyNeedsMon_a: assert property (softwareReady |-> powerMonitor)
    else $error("software ready without power monitor");
  monTiming_a: assert property ($rose(powerMonitor) |-> sinceKey_ff inside {[PADS:PADS+5]})
    else $error("power monitor rose at wrong time");
  bootTiming_a: assert property ($rose(softwareReady) |->
    sinceKey_ff inside {[BOOT:BOOT+5]})
    else $error("software ready rose at wrong time");
  offTogether_a: assert property ($fell(powerMonitor) || $fell(softwareReady) |->
    !powerMonitor && !softwareReady)
    else $error("monitor lines did not drop together");
  cmdHoldsLines_a: assert property (shutdownCommand |=> softwareReady [*3])
    else $error("lines dropped without finalization");
  keyOffLate_a: assert property (keyOe && softwareReady && keyHold_ff <= KEY_OFF |=>
    softwareReady)
    else $error("key shutdown acted too early");
  emergOff_a: assert property ($fell(emergencyOffN) && powerMonitor |->
    powerMonitor [*8] ##[1:EMERG_HOLD] !powerMonitor)
    else $error("emergency off timing wrong");
  // An emergency request may cut a key press short
  keyHoldLen_a: assert property ($fell(keyOe) && !emergencyOe |->
    keyHold_ff inside {[ON_HOLD-1:ON_HOLD+1], [OFF_HOLD-1:OFF_HOLD+1]})
    else $error("key hold length wrong");
  emergHoldLen_a: assert property ($fell(emergencyOe) |-> emergHold_ff inside {[EMERG_HOLD-1:EMERG_HOLD+1]})
    else $error("emergency hold length wrong");
  keyOpenDrain_a: assert property (keyOe |-> !keyOut)
    else $error("key driven high");
  emergOpenDrain_a: assert property (emergencyOe |-> !emergencyOut)
    else $error("emergency line driven high");
  noCmdEarly_a: assert property (shutdownCommand |-> softwareReady)
    else $error("command sent before ready");
  noKeyInBoot_a: assert property ($rose(keyOe) |-> !powerMonitor || softwareReady)
    else $error("key pressed during boot");

  bootSeen_c: cover property ($rose(softwareReady));
  emergSeen_c: cover property ($fell(powerMonitor) && emergencyOe);
  cmdSeen_c: cover property (shutdownCommand);
endmodule : power_seq_monitor
`default_nettype wire

// ### verification/tb_module_power_on_off_sequencer.sv
// Testbench joining host and module sequencers across the power link
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
  cmpCount++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("Error %s expected %0h seen %0h", n, e, g); \
  end \
end
`define WAITC(c) begin \
  wcnt = 0; \
  while (!(c) && wcnt < 1000) begin \
    @(negedge clk); \
    wcnt++; \
  end \
  if (!(c)) begin \
    fails++; \
    $display("Error wait limit expected 1 seen 0"); \
  end \
end
module tb_module_power_on_off_sequencer;
  import power_seq_pkg::*;
  // Shortened timing; the checker's defaults follow these values
  localparam int T_GLITCH = 8;
  localparam int T_PADS = 40;
  localparam int T_BOOT = 60;
  localparam int T_KEY_OFF = 30;
  localparam int T_EMERG = 10;
  localparam int T_ON = 20;
  localparam int T_OFF = 34;
  localparam int T_EMERG_HOLD = 14;
  localparam int T_TIMEOUT = 500;
  logic clk, srst, reqPowerOn, reqHwOff, reqSwOff, reqEmergency;
  logic fastOffEnable, fastOffPin, finalizeDone;
  logic busy, moduleReady, timeoutErr, requestRejected, supplyOffOk, detachReq, finalizing;
  int fails, cmpCount, wcnt, cyc, detachCnt, d;

  power_link_if link();
  power_seq_host #(
    .ON_HOLD_CYCLES(CNT_W'(T_ON)),
    .OFF_HOLD_CYCLES(CNT_W'(T_OFF)),
    .EMERG_HOLD_CYCLES(CNT_W'(T_EMERG_HOLD)),
    .TIMEOUT_CYCLES(CNT_W'(T_TIMEOUT))
  ) u_power_seq_host (
    .clk(clk), .srst(srst), .link(link), .reqPowerOn(reqPowerOn), .reqHwOff(reqHwOff),
    .reqSwOff(reqSwOff), .reqEmergency(reqEmergency), .busy(busy), .moduleReady(moduleReady),
    .timeoutErr(timeoutErr), .requestRejected(requestRejected), .supplyOffOk(supplyOffOk));
  power_seq_device #(
    .GLITCH_CYCLES(CNT_W'(T_GLITCH)),
    .PADS_CYCLES(CNT_W'(T_PADS)),
    .BOOT_CYCLES(CNT_W'(T_BOOT)),
    .KEY_OFF_CYCLES(CNT_W'(T_KEY_OFF)),
    .EMERG_CYCLES(CNT_W'(T_EMERG))
  ) u_power_seq_device (
    .clk(clk), .srst(srst), .link(link), .fastOffEnable(fastOffEnable), .fastOffPin(fastOffPin),
    .finalizeDone(finalizeDone), .detachReq(detachReq), .finalizing(finalizing));
  power_seq_monitor u_power_seq_monitor (
    .clk(clk), .srst(srst), .keyOut(link.keyOut), .keyOe(link.keyOe),
    .emergencyOut(link.emergencyOut), .emergencyOe(link.emergencyOe),
    .shutdownCommand(link.shutdownCommand), .powerMonitor(link.powerMonitor),
    .softwareReady(link.softwareReady), .powerKeyN(link.powerKeyN),
    .emergencyOffN(link.emergencyOffN));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (detachReq === 1'b1) detachCnt++;

  // ==========================================================
  // Shared steps
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    {reqPowerOn, reqHwOff, reqSwOff, reqEmergency} <= m;
    @(posedge clk);
    {reqPowerOn, reqHwOff, reqSwOff, reqEmergency} <= 4'h0;
  endtask : pulse
  task automatic power_up;
    pulse(4'h8);
    `WAITC(moduleReady === 1'b1)
    `CHK("monitor", 1'b1, link.powerMonitor)
    `CHK("swready", 1'b1, link.softwareReady)
    `CHK("busy", 1'b0, busy)
  endtask : power_up
  // Ends finalization and expects a confirmed off
  task automatic finish_off;
    @(posedge clk);
    finalizeDone <= 1'b1;
    @(posedge clk);
    finalizeDone <= 1'b0;
    `WAITC(supplyOffOk === 1'b1)
    `CHK("off monitor", 1'b0, link.powerMonitor)
    `CHK("off swready", 1'b0, link.softwareReady)
    `CHK("supply ok", 1'b1, supplyOffOk)
  endtask : finish_off

  // ==========================================================
  // Scenarios
  task automatic t_on;
    power_up();
    pulse(4'h8);
    @(negedge clk);
    `CHK("on rejected", 1'b1, requestRejected)
    $display("Test power on done");
  endtask : t_on
  task automatic t_sw_off;
    d = detachCnt;
    pulse(4'h2);
    repeat (4) @(negedge clk);
    `CHK("detach", d + 1, detachCnt)
    `CHK("finalizing", 1'b1, finalizing)
    `CHK("held", 1'b1, link.powerMonitor)
    finish_off();
    pulse(4'h4);
    @(negedge clk);
    `CHK("off rejected", 1'b1, requestRejected)
    $display("Test software off done");
  endtask : t_sw_off
  task automatic t_hw_off;
    power_up();
    d = detachCnt;
    pulse(4'h4);
    @(negedge clk);
    `CHK("key low", 1'b0, link.powerKeyN)
    `WAITC(finalizing === 1'b1)
    `CHK("late final", 1'b1, wcnt > T_KEY_OFF)
    // Detach counter samples on the next rising edge
    @(negedge clk);
    `CHK("hw detach", d + 1, detachCnt)
    finish_off();
    $display("Test hardware off done");
  endtask : t_hw_off
  task automatic t_emerg;
    power_up();
    d = detachCnt;
    pulse(4'h1);
    `WAITC(link.powerMonitor === 1'b0)
    `CHK("emerg fast", 1'b1, wcnt <= 16)
    `CHK("no detach", d, detachCnt)
    `WAITC(busy === 1'b0)
    `CHK("released", 1'b1, link.emergencyOffN)
    // Key press cut short by the emergency path must not boot the module
    pulse(4'h8);
    repeat (5) @(posedge clk);
    pulse(4'h1);
    repeat (60) @(negedge clk);
    `CHK("glitch ignored", 1'b0, link.powerMonitor)
    $display("Test emergency done");
  endtask : t_emerg
  task automatic t_fast;
    power_up();
    @(posedge clk);
    fastOffPin <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK("fast disabled", 1'b1, link.powerMonitor)
    @(posedge clk);
    fastOffPin <= 1'b1;
    fastOffEnable <= 1'b1;
    @(posedge clk);
    fastOffPin <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("fast off", 1'b0, link.powerMonitor)
    `WAITC(supplyOffOk === 1'b1)
    `CHK("fast supply", 1'b1, supplyOffOk)
    fastOffEnable <= 1'b0;
    fastOffPin <= 1'b1;
    $display("Test fast off done");
  endtask : t_fast
  task automatic t_timeout;
    power_up();
    pulse(4'h2);
    `WAITC(timeoutErr === 1'b1)
    `CHK("timeout", 1'b1, timeoutErr)
    `CHK("timeout late", 1'b1, wcnt >= T_TIMEOUT)
    pulse(4'h1);
    `WAITC(busy === 1'b0 && link.powerMonitor === 1'b0)
    power_up();
    `CHK("timeout clear", 1'b0, timeoutErr)
    $display("Test timeout done");
  endtask : t_timeout

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // Ceiling well above the thousand or so cycles the tests need
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 20000) begin
        fails++;
        tally_and_finish();
      end
    end
  end

  initial begin
    {srst, reqPowerOn, reqHwOff, reqSwOff, reqEmergency} = 5'h10;
    {fastOffEnable, fastOffPin, finalizeDone} = 3'h2;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_on();
    t_sw_off();
    t_hw_off();
    t_emerg();
    t_fast();
    t_timeout();
    tally_and_finish();
  end
endmodule : tb_module_power_on_off_sequencer
`default_nettype wire
